// *** design/lmt_timer.sv ***
/*
  Mode control and counter of an 8-bit period timer with limit function.
  Assumes a single clock, synchronous reset, and that software writes
  the enable bit through en_set/en_clr pulses and reads enable_bit.
*/
`timescale 1ns/100ps
module lmt_timer
  import lmt_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Control
  input wire logic [MODE_W-1:0] mode,
  input wire logic en_set,
  input wire logic en_clr,
  input wire logic debug_mode,
  input wire logic [WIDTH-1:0] period_value,
  input wire logic [3:0] prescale_select,
  input wire logic [3:0] postscale_select,
  // Trigger source
  input wire logic external_reset_input,
  // Status and outputs
  output logic enable_bit,
  output logic [WIDTH-1:0] count_value,
  output logic running,
  output logic postscaled_pulse_out
);
  generate
    if (WIDTH < 2 || WIDTH > 16) begin : g_chk
      $error("lmt_timer: WIDTH out of range");
    end
  endgenerate

  logic [SYNC_STAGES-1:0] ers_sync;
  logic [SYNC_STAGES-1:0] en_sync;
  logic ers_prev;
  logic [3:0] pre_cnt;
  logic [3:0] post_cnt;
  lmt_state_e state;
  logic [WIDTH-1:0] next_count;
  logic next_enable;
  logic [3:0] next_pre;
  logic [3:0] next_post;
  logic next_pulse;
  lmt_state_e next_state;
  logic ers;
  logic en_s;
  logic rise;
  logic fall;
  logic tick;
  logic match;

  // Second stage only feeds the logic, never the first
  always_ff @(posedge mclk) begin
    if (reset) begin
      ers_sync <= '0;
      en_sync <= '0;
      ers_prev <= 1'b0;
    end else begin
      ers_sync <= {ers_sync[0], external_reset_input};
      en_sync <= {en_sync[0], enable_bit};
      ers_prev <= ers_sync[SYNC_STAGES-1];
    end
  end

  wire [1:0] fam = mode[4:3];
  wire [2:0] var_c = mode[2:0];

  always_comb begin
    ers = ers_sync[SYNC_STAGES-1];
    en_s = en_sync[SYNC_STAGES-1];
    rise = ers & ~ers_prev;
    fall = ~ers & ers_prev;
    // Zero selects 1:1; otherwise tick every select+1 clocks
    tick = (pre_cnt == prescale_select);
    match = (count_value == period_value);
  end

  logic edge_start;
  logic hw_reset;
  logic gate_ok;
  always_comb begin
    edge_start = 1'b0;
    hw_reset = 1'b0;
    gate_ok = 1'b1;
    unique case (var_c)
      V_RISE: edge_start = rise;
      V_FALL: edge_start = fall;
      V_ANY: edge_start = rise | fall;
      V_RR: begin
        edge_start = rise;
        hw_reset = rise;
      end
      V_FF: begin
        edge_start = fall;
        hw_reset = fall;
      end
      V_RLOW: begin
        edge_start = (fam == FAM_MONO) ? ers : rise;
        hw_reset = ~ers;
      end
      V_FHIGH: begin
        edge_start = (fam == FAM_MONO) ? ~ers : fall;
        hw_reset = ers;
      end
      default: edge_start = 1'b0;
    endcase
    // Debug hides every trigger and reset event of the reset source; the hardware gate level still passes
    if (debug_mode) begin
      edge_start = 1'b0;
      hw_reset = 1'b0;
    end
    if (fam == FAM_FREE) begin
      if (var_c == V_RISE) gate_ok = ers;
      if (var_c == V_FALL) gate_ok = ~ers;
    end
  end

  wire valid_mode = (fam == FAM_FREE && (var_c <= V_FALL))
    || fam == FAM_ONESHOT
    || (fam == FAM_MONO && (var_c inside {V_RISE, V_FALL, V_ANY,
                                           V_RLOW, V_FHIGH}));
  wire is_gate = (fam == FAM_FREE) && valid_mode;
  wire clears_en = (fam == FAM_ONESHOT) ||
    (fam == FAM_MONO && var_c >= V_RLOW);

  always_comb begin
    next_count = count_value;
    next_state = state;
    next_enable = enable_bit;
    next_pre = pre_cnt;
    next_post = post_cnt;
    next_pulse = 1'b0;
    if (en_set) next_enable = 1'b1;
    if (en_clr) next_enable = 1'b0;
    if (!valid_mode) begin
      next_state = LMT_IDLE;
    end else if (is_gate) begin
      // Gate pauses hold the count, stretching any PWM phase
      if (en_s && gate_ok && tick) begin
        next_pre = '0;
        next_count = match ? WIDTH'(COUNT_ZERO) : count_value + 1'b1;
        if (match) begin
          if (post_cnt == postscale_select) begin
            next_pulse = 1'b1;
            next_post = '0;
          end else begin
            next_post = post_cnt + 1'b1;
          end
        end
      end else if (en_s && gate_ok) begin
        next_pre = pre_cnt + 1'b1;
      end
    end else begin
      unique case (state)
        LMT_IDLE: begin
          // The synchronized enable lags a hardware clear by two clocks
          if (en_s && enable_bit) begin
            next_state = (var_c == V_SW) ? LMT_RUN : LMT_ARMED;
          end
        end
        LMT_ARMED: begin
          if (!en_s) next_state = LMT_IDLE;
          else if (edge_start) next_state = LMT_RUN;
        end
        LMT_RUN: begin
          if (!en_s) begin
            next_state = LMT_IDLE;
          end else if (hw_reset && !(var_c == V_RR || var_c == V_FF)) begin
            next_count = WIDTH'(COUNT_ZERO);
            next_pre = '0;
            next_post = '0;
          end else if (hw_reset) begin
            next_count = WIDTH'(COUNT_ZERO);
            next_pre = '0;
            next_post = '0;
          end else if (tick) begin
            next_pre = '0;
            if (match) begin
              next_count = WIDTH'(COUNT_ZERO);
              next_pulse = (postscale_select == post_cnt);
              next_post = '0;
              next_state = LMT_DONE;
              if (clears_en && !en_set) next_enable = 1'b0;
            end else begin
              next_count = count_value + 1'b1;
            end
          end else begin
            next_pre = pre_cnt + 1'b1;
          end
        end
        LMT_DONE: begin
          if (!en_s || !enable_bit) next_state = LMT_IDLE;
          else if (fam == FAM_MONO && edge_start && var_c < V_RLOW)
            next_state = LMT_RUN;
        end
        default: next_state = LMT_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      count_value <= WIDTH'(COUNT_ZERO);
      state <= LMT_IDLE;
      enable_bit <= 1'b0;
      pre_cnt <= '0;
      post_cnt <= '0;
      postscaled_pulse_out <= 1'b0;
    end else begin
      count_value <= next_count;
      state <= next_state;
      enable_bit <= next_enable;
      pre_cnt <= next_pre;
      post_cnt <= next_post;
      postscaled_pulse_out <= next_pulse;
    end
  end

  assign running = (state == LMT_RUN) || (is_gate && en_s && gate_ok);

  one_shot_clear_a: assert property (@(posedge mclk) disable iff (reset)
    (state == LMT_RUN && fam == FAM_ONESHOT && en_s && !hw_reset && tick
     && match && !en_set && !en_clr && valid_mode)
    |=> (!enable_bit && count_value == COUNT_ZERO))
    else $error("one-shot did not stop at zero with enable cleared");
  mono_keep_en_a: assert property (@(posedge mclk) disable iff (reset)
    (state == LMT_RUN && fam == FAM_MONO && var_c <= V_ANY && en_s && tick
     && match && enable_bit && !en_clr && valid_mode)
    |=> (enable_bit && count_value == COUNT_ZERO))
    else $error("monostable lost enable at period match");
  sw_gate_hold_a: assert property (@(posedge mclk) disable iff (reset)
    (mode == 5'h00 && !en_s) |=> $stable(count_value))
    else $error("software gate counted while disabled");
  gate_wrap_a: assert property (@(posedge mclk) disable iff (reset)
    (is_gate && en_s && gate_ok && tick && match)
    |=> count_value == COUNT_ZERO)
    else $error("gate mode did not reload zero after match");
  hw_gate_a: assert property (@(posedge mclk) disable iff (reset)
    (mode == 5'h01 && !ers) |=> $stable(count_value))
    else $error("hardware gate counted with input low");
  sync_delay_a: assert property (@(posedge mclk) disable iff (reset)
    $rose(external_reset_input) && !debug_mode ##1 !debug_mode
    |-> ##1 ers_sync[SYNC_STAGES-1])
    else $error("external input not seen two clocks later");
  debug_freeze_a: assert property (@(posedge mclk) disable iff (reset)
    (debug_mode && state == LMT_ARMED) |=> state != LMT_RUN)
    else $error("timer started by a trigger in debug mode");
  post_pulse_a: assert property (@(posedge mclk) disable iff (reset)
    postscaled_pulse_out |-> $past(match) && $past(tick))
    else $error("postscaled pulse without period match");
endmodule : lmt_timer

// *** pkg/lmt_pkg.sv ***
/*
  Constants, mode codes and state type for the limit timer mode control.
  Assumes one 40 MHz clock and inputs synchronous to it.
*/
// What this block does
// - A five-bit mode field picks the family (bits 4:3) and variant (2:0).
// - In debug mode every external trigger and reset event is ignored.
// - One-shot codes 001/010/011 start on enable then a rise/fall/any edge.
// - One-shot 01100 starts and resets on rises, 01101 on falls.
// - One-shot 01110 starts on a rise, resets on low; 01111 the inverse.
// - One-shot: the clock after a period match clears enable, count at zero.
// - Monostable 10001-10011 start on edges and stop at zero keeping enable.
// - Level one-shot 10110/10111 run on a level, reset on the other level.
// - Software gate 00000 counts while enable is set and holds otherwise.
// - In gate modes a period match reloads zero on the next clock.
// - Hardware gate 00001 counts on input high, 00010 on input low.
// - Gating pauses lengthen the PWM period and a high PWM phase.
// - Zero prescale and postscale selections mean a one-to-one ratio.
// - Enable and external input pass a two-clock synchronizer.
// - In gate modes each period match steps the postscaler; every select+1 matches emit one pulse.
package lmt_pkg;
  localparam int MODE_W = 5;
  localparam logic [1:0] FAM_FREE = 2'h0;
  localparam logic [1:0] FAM_ONESHOT = 2'h1;
  localparam logic [1:0] FAM_MONO = 2'h2;
  localparam logic [2:0] V_SW = 3'h0;
  localparam logic [2:0] V_RISE = 3'h1;
  localparam logic [2:0] V_FALL = 3'h2;
  localparam logic [2:0] V_ANY = 3'h3;
  localparam logic [2:0] V_RR = 3'h4;
  localparam logic [2:0] V_FF = 3'h5;
  localparam logic [2:0] V_RLOW = 3'h6;
  localparam logic [2:0] V_FHIGH = 3'h7;
  localparam logic [7:0] PERIOD_RESET = 8'hFF;
  localparam logic [7:0] COUNT_ZERO = 8'h00;
  localparam int SYNC_STAGES = 2;
  typedef enum logic [1:0] {
    LMT_IDLE = 2'h0,
    LMT_ARMED = 2'h1,
    LMT_RUN = 2'h3,
    LMT_DONE = 2'h2
  } lmt_state_e;
endpackage : lmt_pkg

// *** testbench/lmt_trig_src.sv ***
/*
  Model of the on-chip signal that triggers and resets the timer.
  Assumes the bench calls drive between falling edges of mclk.
*/
`timescale 1ns/100ps
module lmt_trig_src (
  // Clock
  input wire logic mclk,
  // Trigger line
  output logic trig
);
  initial trig = 1'b0;
  // Waiting first keeps any edge or level legal after the last one
  task automatic drive(input logic v);
    repeat (6) @(negedge mclk);
    trig = v;
  endtask : drive
endmodule : lmt_trig_src

// *** testbench/tb_top.sv ***
/*
  Self-checking bench for the limit timer mode control.
  Assumes the trigger model and the design with its own assertions.
*/
`timescale 1ns/100ps
module tb_top;
  import lmt_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [4:0] mode = 5'h00;
  logic en_set = 1'b0;
  logic en_clr = 1'b0;
  logic debug_mode = 1'b0;
  logic [7:0] period_value = 8'hFF;
  logic ext;
  logic enable_bit;
  logic [7:0] count_value;
  logic running;
  logic pout;
  logic hit;
  logic [7:0] snap;
  logic [3:0] pre_sel = 4'h0;
  logic [3:0] post_sel = 4'h0;
  int pulses;
  int zeros;
  int num_errors = 0;
  int checked = 0;

  initial begin
    forever #12.5 mclk = ~mclk;
  end

  lmt_trig_src p (.mclk(mclk), .trig(ext));

  lmt_timer #(.WIDTH(8)) dut (
    .mclk(mclk), .reset(reset), .mode(mode), .en_set(en_set),
    .en_clr(en_clr), .debug_mode(debug_mode),
    .period_value(period_value), .prescale_select(pre_sel),
    .postscale_select(post_sel), .external_reset_input(ext),
    .enable_bit(enable_bit), .count_value(count_value),
    .running(running), .postscaled_pulse_out(pout)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    if (num_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  task automatic start(input logic [4:0] m, input logic [7:0] per);
    @(negedge mclk);
    reset = 1'b1;
    mode = m;
    period_value = per;
    debug_mode = 1'b0;
    repeat (2) @(negedge mclk);
    reset = 1'b0;
  endtask : start

  task automatic pulse(input bit clr);
    @(negedge mclk);
    if (clr) en_clr = 1'b1;
    else en_set = 1'b1;
    @(negedge mclk);
    en_set = 1'b0;
    en_clr = 1'b0;
  endtask : pulse

  // Bounded wait so a stuck counter cannot hang the run
  task automatic wait_for(input logic [7:0] v);
    hit = 1'b0;
    for (int i = 0; i < 30 && !hit; i++) begin
      @(negedge mclk);
      hit = (count_value === v);
    end
  endtask : wait_for

  task automatic t_swgate();
    start(5'h00, 8'h03);
    pulse(0);
    wait_for(8'h03);
    check({7'h00, hit}, 8'h01);
    @(negedge mclk);
    check(count_value, 8'h00);
    @(negedge mclk);
    check(count_value, 8'h01);
    pulse(1);
    repeat (4) @(negedge mclk);
    snap = count_value;
    repeat (4) @(negedge mclk);
    check(count_value, snap);
  endtask : t_swgate

  task automatic t_oneshot();
    start(5'h08, 8'h02);
    pulse(0);
    wait_for(8'h02);
    check({7'h00, hit}, 8'h01);
    check({7'h00, running}, 8'h01);
    @(negedge mclk);
    check(count_value, 8'h00);
    check({7'h00, enable_bit}, 8'h00);
    check({7'h00, running}, 8'h00);
    check({7'h00, pout}, 8'h01);
    repeat (5) @(negedge mclk);
    check(count_value, 8'h00);
  endtask : t_oneshot

  task automatic t_edge(input logic dbg);
    start(5'h09, 8'h04);
    debug_mode = dbg;
    pulse(0);
    repeat (8) @(negedge mclk);
    check(count_value, 8'h00);
    p.drive(1'b1);
    wait_for(8'h01);
    check({7'h00, hit}, {7'h00, !dbg});
    p.drive(1'b0);
  endtask : t_edge

  task automatic t_mono();
    start(5'h11, 8'h02);
    pulse(0);
    p.drive(1'b1);
    wait_for(8'h02);
    check({7'h00, hit}, 8'h01);
    @(negedge mclk);
    check(count_value, 8'h00);
    check({7'h00, enable_bit}, 8'h01);
    p.drive(1'b0);
    p.drive(1'b1);
    wait_for(8'h01);
    check({7'h00, hit}, 8'h01);
    p.drive(1'b0);
  endtask : t_mono

  task automatic t_hold(input logic [4:0] m, input logic gate);
    start(m, 8'h03);
    pulse(0);
    repeat (8) @(negedge mclk);
    check(count_value, 8'h00);
    check({7'h00, running}, 8'h00);
    p.drive(1'b1);
    wait_for(8'h01);
    check({7'h00, hit}, {7'h00, gate});
    check({7'h00, running}, {7'h00, gate});
    p.drive(1'b0);
  endtask : t_hold

  task automatic t_gate_low();
    start(5'h02, 8'hF0);
    pulse(0);
    wait_for(8'h03);
    check({7'h00, hit}, 8'h01);
    p.drive(1'b1);
    repeat (4) @(negedge mclk);
    snap = count_value;
    repeat (4) @(negedge mclk);
    check(count_value, snap);
    p.drive(1'b0);
  endtask : t_gate_low

  // A second rising edge clears the running count
  task automatic t_rreset();
    start(5'h0C, 8'h40);
    pulse(0);
    p.drive(1'b1);
    wait_for(8'h03);
    check({7'h00, hit}, 8'h01);
    p.drive(1'b0);
    p.drive(1'b1);
    wait_for(8'h00);
    check({7'h00, hit}, 8'h01);
    p.drive(1'b0);
  endtask : t_rreset

  task automatic t_lvl();
    start(5'h16, 8'h10);
    pulse(0);
    p.drive(1'b1);
    wait_for(8'h02);
    check({7'h00, hit}, 8'h01);
    p.drive(1'b0);
    wait_for(8'h00);
    check({7'h00, hit}, 8'h01);
    p.drive(1'b1);
    wait_for(8'h10);
    check({7'h00, hit}, 8'h01);
    @(negedge mclk);
    check(count_value, 8'h00);
    check({7'h00, enable_bit}, 8'h00);
    p.drive(1'b0);
  endtask : t_lvl

  // Window of 80 clocks spans whole pulse and count periods at any phase
  task automatic t_scale();
    pre_sel = 4'h1;
    post_sel = 4'h1;
    start(5'h00, 8'h01);
    pulse(0);
    repeat (8) @(negedge mclk);
    pulses = 0;
    zeros = 0;
    repeat (80) begin
      @(negedge mclk);
      pulses += pout;
      zeros += (count_value == 8'h00);
    end
    check(8'(pulses), 8'h0A);
    check(8'(zeros), 8'h28);
    pre_sel = 4'h0;
    post_sel = 4'h0;
  endtask : t_scale

  initial begin
    #100000;
    num_errors++;
    summarize();
  end

  initial begin
    repeat (5) @(negedge mclk);
    reset = 1'b0;
    t_swgate();
    t_oneshot();
    t_edge(1'b0);
    t_edge(1'b1);
    t_mono();
    t_hold(5'h01, 1'b1);
    t_hold(5'h14, 1'b0);
    t_gate_low();
    t_rreset();
    t_lvl();
    t_scale();
    summarize();
  end
endmodule : tb_top
